// >>> common/sct_pkg.sv
// shared constants for the sideband command tag tracker
package sct_pkg;
  localparam int TAG_W         = 8;
  localparam int OPC_W         = 8;
  localparam int DATA_W        = 16;
  localparam int CHAN_W        = 3;
  localparam int PKG_W         = 3;
  localparam logic [7:0] TAG_NONE      = 8'h00;
  localparam logic [7:0] TAG_FIRST     = 8'h01;
  localparam logic [7:0] OPC_READY_REL = 8'h00;
  localparam logic [7:0] OPC_CAP_QUERY = 8'h16;
  localparam logic [7:0] OPC_CFG_WRITE = 8'h20;
  localparam logic [7:0] OPC_CFG_READ  = 8'h21;
  localparam int RSP_TIMEOUT_NS = 2000;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int RETRY_MAX       = 3;
  localparam logic [15:0] CFG_RESET = 16'h0000;
endpackage : sct_pkg

// >>> common/sct_link_if.sv
// link between the host manager and the controller: command and answer channels
`timescale 1ns/1ps
interface sct_link_if;
  logic       cmd_valid;
  logic [7:0] cmd_tag;
  logic [7:0] cmd_opc;
  logic [2:0] cmd_pkg;
  logic [2:0] cmd_chan;
  logic [15:0] cmd_data;
  logic       rsp_valid;
  logic       rsp_event;
  logic [7:0] rsp_tag;
  logic [2:0] rsp_pkg;
  logic [2:0] rsp_chan;
  logic [15:0] rsp_data;
  modport ctrl (input cmd_valid, cmd_tag, cmd_opc, cmd_pkg, cmd_chan, cmd_data,
                output rsp_valid, rsp_event, rsp_tag, rsp_pkg, rsp_chan, rsp_data);
  modport mgr  (output cmd_valid, cmd_tag, cmd_opc, cmd_pkg, cmd_chan, cmd_data,
                input rsp_valid, rsp_event, rsp_tag, rsp_pkg, rsp_chan, rsp_data);
endinterface : sct_link_if

// >>> logic/sct_tag_gen.sv
// host-side request tag generator, never yields the reserved zero tag
`timescale 1ns/1ps
module sct_tag_gen (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       advance,
  output logic [7:0]      tag
);
  typedef struct packed {
    logic [7:0] tag_r;
  } sct_tg_s;
  sct_tg_s st_r;
  sct_tg_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (advance) begin
      // wrap skips zero so a fresh command never looks like an event
      st_nxt.tag_r = (st_r.tag_r == 8'hff) ? sct_pkg::TAG_FIRST : st_r.tag_r + 8'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{tag_r: 8'h01};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tag = st_r.tag_r;
endmodule : sct_tag_gen

// >>> logic/sct_ctrl_end.sv
// controller end: tag check, retry replay, execution and unsolicited events
`timescale 1ns/1ps
// Operation
// - tags are eight bits, zero unused
// - response echoes the command tag
// - same tag as previous means retry
// - retry answers with stored earlier response
// - different tag executes as new command
// - initial state entry forgets earlier tags
// - manager gives each new command fresh tag
// - manager retry reuses original tag
// - manager may check response tag matches
// - unsolicited events carry tag zero
// - only the manager originates commands
// - link carries pass-through and control traffic
// - arbitrated discovery uses ready-release only
// - discovery walks from lowest ids upward
// - channels numbered from zero, silence ends
// - silent channel zero means package absent
// - manager queries capabilities of found channels
// - configure channels in any order
// - one outstanding command per package
// - each new response replaces stored copy
module sct_ctrl_end #(
  parameter logic [2:0] PKG_ID    = 3'h0,
  parameter int         NUM_CHAN  = 2
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  sct_link_if.ctrl         LINK,
  input  wire logic        INIT_STATE_ENTER,
  input  wire logic        EVENT_REQ,
  input  wire logic [2:0]  EVENT_CHAN,
  input  wire logic [15:0] EVENT_CODE,
  output logic [15:0]      CFG_OUT,
  output logic             RETRY_SEEN,
  output logic             CHAN_ENABLED
);
  initial begin
    if (NUM_CHAN < 1 || NUM_CHAN > 8) $error("NUM_CHAN out of range");
  end

  typedef struct packed {
    logic        last_vld_r;
    logic [7:0]  last_tag_r;
    logic        rsp_valid_r;
    logic        rsp_event_r;
    logic [7:0]  rsp_tag_r;
    logic [2:0]  rsp_pkg_r;
    logic [2:0]  rsp_chan_r;
    logic [15:0] rsp_data_r;
    logic [15:0] saved_data_r;
    logic [2:0]  saved_chan_r;
    logic [15:0] cfg_r;
    logic        retry_r;
    logic        enabled_r;
    logic        ev_pend_r;
    logic [2:0]  ev_chan_r;
    logic [15:0] ev_code_r;
  } sct_ce_s;

  sct_ce_s st_r;
  sct_ce_s st_nxt;

  function automatic logic [15:0] exec_data(input logic [7:0] opc,
                                            input logic [15:0] cfg,
                                            input logic [15:0] arg);
    logic [15:0] d;
    d = 16'h0000;
    if (opc == sct_pkg::OPC_CAP_QUERY) begin
      d = 16'(NUM_CHAN);
    end else if (opc == sct_pkg::OPC_CFG_READ) begin
      d = cfg;
    end else if (opc == sct_pkg::OPC_CFG_WRITE) begin
      d = arg;
    end
    return d;
  endfunction : exec_data

  logic addressed;
  assign addressed = LINK.cmd_valid && (LINK.cmd_pkg == PKG_ID)
                     && ({29'h0, LINK.cmd_chan} < NUM_CHAN);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp_valid_r = 1'b0;
    st_nxt.rsp_event_r = 1'b0;
    st_nxt.retry_r     = 1'b0;
    // event request latched; set wins over the consume below
    if (EVENT_REQ) begin
      st_nxt.ev_pend_r = 1'b1;
      st_nxt.ev_chan_r = EVENT_CHAN;
      st_nxt.ev_code_r = EVENT_CODE;
    end
    if (INIT_STATE_ENTER) begin
      st_nxt.last_vld_r = 1'b0;
      st_nxt.enabled_r  = 1'b0;
    end else if (addressed) begin
      // here the controller answers an addressed command; commands come from the link alone
      st_nxt.rsp_valid_r = 1'b1;
      st_nxt.rsp_tag_r   = LINK.cmd_tag;
      st_nxt.rsp_pkg_r   = PKG_ID;
      st_nxt.rsp_chan_r  = LINK.cmd_chan;
      if (st_r.last_vld_r && LINK.cmd_tag == st_r.last_tag_r) begin
        // replay avoids repeating a config write's side effect
        st_nxt.retry_r    = 1'b1;
        st_nxt.rsp_data_r = st_r.saved_data_r;
        st_nxt.rsp_chan_r = st_r.saved_chan_r;
      end else begin
        st_nxt.rsp_data_r   = exec_data(LINK.cmd_opc, st_r.cfg_r, LINK.cmd_data);
        st_nxt.saved_data_r = st_nxt.rsp_data_r;
        st_nxt.saved_chan_r = LINK.cmd_chan;
        st_nxt.last_tag_r   = LINK.cmd_tag;
        st_nxt.last_vld_r   = 1'b1;
        if (LINK.cmd_opc == sct_pkg::OPC_CFG_WRITE) begin
          st_nxt.cfg_r     = LINK.cmd_data;
          st_nxt.enabled_r = 1'b1;
        end
      end
    end else if (st_r.ev_pend_r && !LINK.cmd_valid) begin
      // events only go out when no answer is due, so answers are never delayed
      st_nxt.rsp_valid_r = 1'b1;
      st_nxt.rsp_event_r = 1'b1;
      st_nxt.rsp_tag_r   = sct_pkg::TAG_NONE;
      st_nxt.rsp_pkg_r   = PKG_ID;
      st_nxt.rsp_chan_r  = st_r.ev_chan_r;
      st_nxt.rsp_data_r  = st_r.ev_code_r;
      st_nxt.ev_pend_r   = EVENT_REQ;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_r <= '{cfg_r: sct_pkg::CFG_RESET, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign LINK.rsp_valid = st_r.rsp_valid_r;
  assign LINK.rsp_event = st_r.rsp_event_r;
  assign LINK.rsp_tag   = st_r.rsp_tag_r;
  assign LINK.rsp_pkg   = st_r.rsp_pkg_r;
  assign LINK.rsp_chan  = st_r.rsp_chan_r;
  assign LINK.rsp_data  = st_r.rsp_data_r;
  assign CFG_OUT        = st_r.cfg_r;
  assign RETRY_SEEN     = st_r.retry_r;
  assign CHAN_ENABLED   = st_r.enabled_r;
endmodule : sct_ctrl_end

// >>> logic/sct_mgr_end.sv
// host manager end: discovery walk, capability query, configuration, retry
`timescale 1ns/1ps
module sct_mgr_end #(
  parameter int         NUM_PKG   = 2,
  parameter int         MAX_CHAN  = 4,
  parameter int         TIMEOUT   = sct_pkg::RSP_TIMEOUT_CYC,
  parameter int         RETRIES   = sct_pkg::RETRY_MAX
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  sct_link_if.mgr          LINK,
  input  wire logic        START,
  input  wire logic [15:0] CFG_VALUE,
  output logic             DONE,
  output logic [7:0]       CHAN_FOUND,
  output logic             TAG_MISMATCH,
  output logic             EVENT_SEEN
);
  initial begin
    if (NUM_PKG < 1 || NUM_PKG > 8 || MAX_CHAN < 1 || MAX_CHAN > 8 || TIMEOUT < 1)
      $error("manager parameters out of range");
  end

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_SEND = 3'b001, S_WAIT = 3'b011, S_NEXT = 3'b010, S_DONE = 3'b110
  } sct_st_e;
  typedef enum logic [1:0] {P_DISC = 2'h0, P_CAP = 2'h1, P_CFG = 2'h2} sct_ph_e;

  typedef struct packed {
    sct_st_e     st_r;
    sct_ph_e     ph_r;
    logic [2:0]  pkg_r;
    logic [2:0]  chan_r;
    logic [1:0]  tries_r;
    logic [15:0] tmo_r;
    logic [7:0]  found_r;
    logic        cmd_valid_r;
    logic [7:0]  cmd_tag_r;
    logic [7:0]  cmd_opc_r;
    logic [15:0] cmd_data_r;
    logic        done_r;
    logic        mism_r;
    logic        event_r;
  } sct_me_s;

  sct_me_s st_r;
  sct_me_s st_nxt;
  logic    tag_adv;
  logic [7:0] new_tag;

  sct_tag_gen u_tag (
    .clk     (SYS_CLK),
    .rst     (RESET),
    .advance (tag_adv),
    .tag     (new_tag)
  );

  function automatic logic [7:0] phase_opc(input sct_ph_e ph);
    logic [7:0] o;
    o = sct_pkg::OPC_READY_REL;
    if (ph == P_CAP) o = sct_pkg::OPC_CAP_QUERY;
    else if (ph == P_CFG) o = sct_pkg::OPC_CFG_WRITE;
    return o;
  endfunction : phase_opc

  logic rsp_hit;
  assign rsp_hit = LINK.rsp_valid && !LINK.rsp_event && LINK.rsp_pkg == st_r.pkg_r
                   && LINK.rsp_chan == st_r.chan_r;

  always_comb begin
    st_nxt = st_r;
    tag_adv = 1'b0;
    st_nxt.cmd_valid_r = 1'b0;
    st_nxt.mism_r  = 1'b0;
    st_nxt.event_r = LINK.rsp_valid && LINK.rsp_event && LINK.rsp_tag == sct_pkg::TAG_NONE;
    case (st_r.st_r)
      S_IDLE: begin
        if (START) begin
          st_nxt.st_r = S_SEND;
          st_nxt.ph_r = P_DISC;
          st_nxt.pkg_r = 3'h0;
          st_nxt.chan_r = 3'h0;
          st_nxt.tries_r = 2'h0;
          st_nxt.found_r = 8'h00;
          st_nxt.done_r = 1'b0;
        end
      end
      S_SEND: begin
        st_nxt.cmd_valid_r = 1'b1;
        // a retry keeps the old tag; a first attempt takes a fresh one
        st_nxt.cmd_tag_r = new_tag;
        st_nxt.cmd_opc_r = phase_opc(st_r.ph_r);
        st_nxt.cmd_data_r = CFG_VALUE;
        st_nxt.tmo_r = 16'h0000;
        st_nxt.st_r = S_WAIT;
      end
      S_WAIT: begin
        st_nxt.tmo_r = st_r.tmo_r + 16'h0001;
        if (rsp_hit) begin
          st_nxt.mism_r = LINK.rsp_tag != st_r.cmd_tag_r;
          tag_adv = 1'b1;
          st_nxt.tries_r = 2'h0;
          if (st_r.ph_r == P_DISC && st_r.pkg_r == 3'h0) begin
            st_nxt.found_r[st_r.chan_r] = 1'b1;
          end
          st_nxt.st_r = S_NEXT;
        end else if (st_r.tmo_r == 16'(TIMEOUT - 1)) begin
          if (st_r.tries_r == 2'(RETRIES - 1)) begin
            // silence after retries ends the channel walk
            tag_adv = 1'b1;
            st_nxt.tries_r = 2'h0;
            st_nxt.chan_r = 3'(MAX_CHAN - 1);
            st_nxt.st_r = S_NEXT;
          end else begin
            st_nxt.tries_r = st_r.tries_r + 2'h1;
            st_nxt.st_r = S_SEND;
          end
        end
      end
      S_NEXT: begin
        st_nxt.st_r = S_SEND;
        if (st_r.chan_r != 3'(MAX_CHAN - 1)) begin
          st_nxt.chan_r = st_r.chan_r + 3'h1;
        end else if (st_r.pkg_r != 3'(NUM_PKG - 1)) begin
          st_nxt.chan_r = 3'h0;
          st_nxt.pkg_r = st_r.pkg_r + 3'h1;
        end else if (st_r.ph_r != P_CFG) begin
          st_nxt.chan_r = 3'h0;
          st_nxt.pkg_r = 3'h0;
          st_nxt.ph_r = (st_r.ph_r == P_DISC) ? P_CAP : P_CFG;
        end else begin
          st_nxt.st_r = S_DONE;
          st_nxt.done_r = 1'b1;
        end
      end
      S_DONE: begin
        if (START) st_nxt.st_r = S_IDLE;
      end
      default: st_nxt.st_r = S_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_r <= '{st_r: S_IDLE, ph_r: P_DISC, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign LINK.cmd_valid = st_r.cmd_valid_r;
  assign LINK.cmd_tag   = st_r.cmd_tag_r;
  assign LINK.cmd_opc   = st_r.cmd_opc_r;
  assign LINK.cmd_pkg   = st_r.pkg_r;
  assign LINK.cmd_chan  = st_r.chan_r;
  assign LINK.cmd_data  = st_r.cmd_data_r;
  assign DONE           = st_r.done_r;
  assign CHAN_FOUND     = st_r.found_r;
  assign TAG_MISMATCH   = st_r.mism_r;
  assign EVENT_SEEN     = st_r.event_r;
endmodule : sct_mgr_end

// >>> dv/sct_link_asserts.sv
// checker for the link between manager end and controller end
`timescale 1ns/1ps
module sct_link_asserts #(
  parameter logic [2:0] PKG_ID   = 3'h0,
  parameter int         NUM_CHAN = 2
) (
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_tag,
  input wire logic [7:0]  cmd_opc,
  input wire logic [2:0]  cmd_pkg,
  input wire logic [2:0]  cmd_chan,
  input wire logic [15:0] cmd_data,
  input wire logic        rsp_valid,
  input wire logic        rsp_event,
  input wire logic [7:0]  rsp_tag,
  input wire logic [2:0]  rsp_pkg,
  input wire logic [2:0]  rsp_chan,
  input wire logic [15:0] rsp_data
);
  logic       ans_r;
  logic [7:0] last_r;
  wire logic  hit = cmd_valid && cmd_pkg == PKG_ID && cmd_chan < NUM_CHAN;
  // a silent command leaves ans_r low, so a retry may reuse its tag
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ans_r  <= 1'b0;
      last_r <= 8'h00;
    end else if (cmd_valid) begin
      ans_r  <= 1'b0;
      last_r <= cmd_tag;
    end else if (rsp_valid && !rsp_event) begin
      ans_r  <= 1'b1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  a_tag_nonzero: assert property (cmd_valid |-> cmd_tag != 8'h00)
    else $error("command with zero tag");
  a_answer_next: assert property (hit |=> rsp_valid && !rsp_event)
    else $error("no answer one cycle after command");
  a_unaddr_quiet: assert property (cmd_valid && !hit |=> !rsp_valid || rsp_event)
    else $error("answer to unaddressed command");
  a_tag_echo: assert property (rsp_valid && !rsp_event |-> rsp_tag == $past(cmd_tag))
    else $error("answer tag differs from command tag");
  a_rsp_cause: assert property (rsp_valid && !rsp_event |-> $past(cmd_valid))
    else $error("answer without command");
  a_event_zero: assert property (rsp_valid && rsp_event |-> rsp_tag == 8'h00)
    else $error("event with nonzero tag");
  a_cmd_spaced: assert property (cmd_valid |=> !cmd_valid)
    else $error("second command while one outstanding");
  a_fresh_tag: assert property (cmd_valid && ans_r |-> cmd_tag != last_r)
    else $error("new command reuses answered tag");
endmodule : sct_link_asserts

// >>> dv/test_sideband_cmd_instance_tracker.sv
// bench: both ends joined, plus a second controller driven directly
`timescale 1ns/1ps
module test_sideband_cmd_instance_tracker;
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic        start     = 1'b0;
  logic        ev_req    = 1'b0;
  logic        init_b    = 1'b0;
  logic        init_a    = 1'b0;
  logic        ev_req_b  = 1'b0;
  logic [2:0]  ev_chan   = 3'h1;
  logic [2:0]  ev_chan_b = 3'h0;
  logic [15:0] ev_code   = 16'h00e7;
  logic [15:0] ev_code_b = 16'h0000;
  logic        mis_seen  = 1'b0;
  logic [15:0] cfg_value = 16'h3c5a;
  logic [15:0] cfg_out, cfg_out_b;
  logic        retry_seen, retry_b, chan_en, chan_en_b, done, tag_mis, event_seen;
  logic [7:0]  chan_found;
  int          bad_count = 0;
  int          checked   = 0;
  sct_link_if link ();
  sct_link_if link_b ();
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (tag_mis === 1'b1) mis_seen <= 1'b1;
  sct_ctrl_end #(.PKG_ID(3'h0), .NUM_CHAN(2)) i_sct_ctrl_end (
    .SYS_CLK(sys_clk), .RESET(reset), .LINK(link.ctrl), .INIT_STATE_ENTER(init_a),
    .EVENT_REQ(ev_req), .EVENT_CHAN(ev_chan), .EVENT_CODE(ev_code), .CFG_OUT(cfg_out),
    .RETRY_SEEN(retry_seen), .CHAN_ENABLED(chan_en));
  sct_mgr_end #(.NUM_PKG(2), .MAX_CHAN(4), .TIMEOUT(4), .RETRIES(3)) i_sct_mgr_end (
    .SYS_CLK(sys_clk), .RESET(reset), .LINK(link.mgr), .START(start), .CFG_VALUE(cfg_value),
    .DONE(done), .CHAN_FOUND(chan_found), .TAG_MISMATCH(tag_mis), .EVENT_SEEN(event_seen));
  // second controller lets the bench repeat answered tags; the manager repeats a tag only when retrying an unanswered command
  sct_ctrl_end #(.PKG_ID(3'h0), .NUM_CHAN(2)) i_sct_ctrl_end_b (
    .SYS_CLK(sys_clk), .RESET(reset), .LINK(link_b.ctrl), .INIT_STATE_ENTER(init_b),
    .EVENT_REQ(ev_req_b), .EVENT_CHAN(ev_chan_b), .EVENT_CODE(ev_code_b), .CFG_OUT(cfg_out_b),
    .RETRY_SEEN(retry_b), .CHAN_ENABLED(chan_en_b));
  sct_link_asserts #(.PKG_ID(3'h0), .NUM_CHAN(2)) i_asserts (
    .SYS_CLK(sys_clk), .RESET(reset), .cmd_valid(link.cmd_valid), .cmd_tag(link.cmd_tag),
    .cmd_opc(link.cmd_opc), .cmd_pkg(link.cmd_pkg), .cmd_chan(link.cmd_chan),
    .cmd_data(link.cmd_data), .rsp_valid(link.rsp_valid), .rsp_event(link.rsp_event),
    .rsp_tag(link.rsp_tag), .rsp_pkg(link.rsp_pkg), .rsp_chan(link.rsp_chan),
    .rsp_data(link.rsp_data));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_up();
    check("wait_bound", 16'h0000, 16'h0001);
    finish_test();
  endtask : give_up
  task automatic t_discovery();
    int n;
    @(negedge sys_clk) start = 1'b1;
    @(negedge sys_clk) start = 1'b0;
    for (n = 0; n < 4000 && done !== 1'b1; n++) @(negedge sys_clk);
    if (n == 4000) give_up();
    check("chan_found", {8'h00, chan_found}, 16'h0003);
    check("cfg_out", cfg_out, cfg_value);
    check("chan_en", {15'h0000, chan_en}, 16'h0001);
    check("tag_mismatch", {15'h0000, mis_seen}, 16'h0000);
  endtask : t_discovery
  task automatic t_event();
    int n;
    @(negedge sys_clk) ev_req = 1'b1;
    @(negedge sys_clk) ev_req = 1'b0;
    for (n = 0; n < 20 && !(link.rsp_valid === 1'b1 && link.rsp_event === 1'b1); n++)
      @(negedge sys_clk);
    if (n == 20) give_up();
    check("event_tag", {8'h00, link.rsp_tag}, 16'h0000);
    check("event_chan", {13'h0000, link.rsp_chan}, 16'h0001);
    check("event_code", link.rsp_data, 16'h00e7);
    for (n = 0; n < 3 && event_seen !== 1'b1; n++) @(negedge sys_clk);
    check("event_seen", {15'h0000, event_seen}, 16'h0001);
  endtask : t_event
  // one command on the second link, answer judged in the cycle it stands
  task automatic send_b(input logic [7:0] tag, input logic [7:0] opc, input logic [15:0] data,
                        input logic [15:0] exp, input logic retry);
    @(negedge sys_clk);
    link_b.cmd_valid = 1'b1;
    link_b.cmd_tag   = tag;
    link_b.cmd_opc   = opc;
    link_b.cmd_data  = data;
    @(negedge sys_clk) link_b.cmd_valid = 1'b0;
    check("rsp_valid", {15'h0000, link_b.rsp_valid}, 16'h0001);
    check("rsp_tag", {8'h00, link_b.rsp_tag}, {8'h00, tag});
    check("rsp_data", link_b.rsp_data, exp);
    check("retry_seen", {15'h0000, retry_b}, {15'h0000, retry});
  endtask : send_b
  task automatic t_retry();
    send_b(8'h05, sct_pkg::OPC_CFG_WRITE, 16'h1234, 16'h1234, 1'b0);
    send_b(8'h05, sct_pkg::OPC_CFG_WRITE, 16'h5678, 16'h1234, 1'b1);
    check("cfg_retry", cfg_out_b, 16'h1234);
    send_b(8'h06, sct_pkg::OPC_CFG_WRITE, 16'h5678, 16'h5678, 1'b0);
    send_b(8'h06, sct_pkg::OPC_CFG_READ, 16'h0000, 16'h5678, 1'b1);
    @(negedge sys_clk) init_b = 1'b1;
    @(negedge sys_clk) init_b = 1'b0;
    send_b(8'h06, sct_pkg::OPC_CFG_WRITE, 16'h9abc, 16'h9abc, 1'b0);
    check("cfg_init", cfg_out_b, 16'h9abc);
    check("chan_en_b", {15'h0000, chan_en_b}, 16'h0001);
  endtask : t_retry
  initial begin
    link_b.cmd_valid = 1'b0;
    link_b.cmd_tag   = 8'h01;
    link_b.cmd_opc   = 8'h00;
    link_b.cmd_pkg   = 3'h0;
    link_b.cmd_chan  = 3'h0;
    link_b.cmd_data  = 16'h0000;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    t_discovery();
    t_event();
    t_retry();
    finish_test();
  end
endmodule : test_sideband_cmd_instance_tracker
